// file: include/led_consts.vh
// Constants for the latch edge detector.
// Included by the design files; definitions only.
`ifndef LED_CONSTS_VH
`define LED_CONSTS_VH

`define LED_CH_WIDE      2
`define LED_CH_NARROW    1
`define LED_CFG_OFF      1'h0
`define LED_BIT_OFF      1'h0
`define LED_BIT_ON       1'h1
`define LED_MODE_NONE    4'h1
`define LED_MODE_RISE    4'h2
`define LED_MODE_FALL    4'h4
`define LED_MODE_BOTH    4'h8
`define LED_PIN_CH0      0
`define LED_PIN_CH1      1
`define LED_SYNC_RESET   2'h0

`endif

// file: hdl/led_channel.v
// One latch edge detection channel: synchroniser, edge compare and strobe.
// Assumes the input is an asynchronous pin and the enables are on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "led_consts.vh"

module led_channel (
    input  wire sys_clk_i,
    input  wire rst_i,
    input  wire pin_i,
    input  wire rise_en_i,
    input  wire fall_en_i,
    output reg  strobe_o
);

    reg [1:0] sync;
    reg       prev;

    wire cur  = sync[1];
    wire rise = cur & ~prev;
    wire fall = ~cur & prev;

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync     <= `LED_SYNC_RESET;
            prev     <= `LED_BIT_OFF;
            strobe_o <= `LED_BIT_OFF;
        end else begin
            // Stage 0 feeds only stage 1
            sync     <= {sync[0], pin_i};
            prev     <= cur;                                        // [RULE11]
            // Either-edge pulse when both enables are set
            strobe_o <= (rise_en_i & rise) | (fall_en_i & fall);    // [RULE1] [RULE2] [RULE11]
        end
    end

endmodule
`default_nettype wire

// file: hdl/led_latch_detect.v
// Latch event detector: turns latch pins into one-cycle latch strobes.
// Assumes each counter stage copies its count on a high strobe.
`timescale 1ns/1ps
`default_nettype none
`include "led_consts.vh"

// Overview of operation
// RULE1: A low-to-high input with rising sensing enabled gives a one-cycle high output.
// RULE2: A high-to-low input with falling sensing enabled gives a one-cycle high output.
// RULE3: Each channel has its own rising and falling enable, both off by default.
// RULE4: Configuration of one channel governs only that channel.
// RULE5: Channel 0 reads latch pin 0 and channel 1 reads latch pin 1, fixed.
// RULE6: Channel 0 drives counter stage 0 latch and channel 1 drives stage 1 latch.
// RULE7: In the 32-bit configuration there is no second output channel.
// RULE8: In the 32-bit configuration only the first latch pin is monitored.
// RULE9: Each channel takes a single-bit input from the latch pins only.
// RULE10: A high strobe at a stage latch input copies that stage count into its hold register.
// RULE11: With both enables set either edge pulses, edges found against the previous sample.
module led_latch_detect #(
    parameter WIDE32 = 0
) (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    input  wire [1:0] latch_pin_i,
    input  wire [1:0] rise_en_i,
    input  wire [1:0] fall_en_i,
    output wire [1:0] stage_latch_o
);

    // A pin level shorter than one clock may be missed by the synchroniser.
    // A pin already high at reset release reads as a rising edge.
    // Strobes appear two clocks after the pin change is first sampled.

    // Channels built: one in 32-bit use, two otherwise
    localparam NCH = WIDE32 ? `LED_CH_NARROW : `LED_CH_WIDE;

    // Channel n always reads pin n and feeds stage n
    localparam CH0 = `LED_PIN_CH0;
    localparam CH1 = `LED_PIN_CH1;

    // Sense modes of one channel, one-hot
    localparam [3:0] MODE_NONE = `LED_MODE_NONE;
    localparam [3:0] MODE_RISE = `LED_MODE_RISE;
    localparam [3:0] MODE_FALL = `LED_MODE_FALL;
    localparam [3:0] MODE_BOTH = `LED_MODE_BOTH;

    // Folds the two enables of one channel into its mode
    function [3:0] mode_of;
        input rise;
        input fall;
        begin
            if (rise & fall) begin
                mode_of = MODE_BOTH;
            end else if (rise) begin
                mode_of = MODE_RISE;
            end else if (fall) begin
                mode_of = MODE_FALL;
            end else begin
                mode_of = MODE_NONE;
            end
        end
    endfunction

    // Rising sensing is on in the rise and both modes
    function mode_rise;
        input [3:0] mode;
        begin
            case (mode)
                MODE_NONE: begin
                    mode_rise = `LED_CFG_OFF;
                end
                MODE_RISE: begin
                    mode_rise = `LED_BIT_ON;
                end
                MODE_FALL: begin
                    mode_rise = `LED_CFG_OFF;
                end
                MODE_BOTH: begin
                    mode_rise = `LED_BIT_ON;
                end
                default: begin
                    mode_rise = `LED_CFG_OFF;
                end
            endcase
        end
    endfunction

    // Falling sensing is on in the fall and both modes
    function mode_fall;
        input [3:0] mode;
        begin
            case (mode)
                MODE_NONE: begin
                    mode_fall = `LED_CFG_OFF;
                end
                MODE_RISE: begin
                    mode_fall = `LED_CFG_OFF;
                end
                MODE_FALL: begin
                    mode_fall = `LED_BIT_ON;
                end
                MODE_BOTH: begin
                    mode_fall = `LED_BIT_ON;
                end
                default: begin
                    mode_fall = `LED_CFG_OFF;
                end
            endcase
        end
    endfunction

    // True when channel idx exists in this build
    function chan_built;
        input integer idx;
        begin
            chan_built = (idx < NCH);
        end
    endfunction

    // Registered modes; the pin path sees an enable one cycle late
    reg  [3:0] mode0;
    reg  [3:0] mode1;
    reg  [3:0] next_mode0;
    reg  [3:0] next_mode1;

    // Raw enables per channel, before registering
    wire       rise_req0;
    wire       fall_req0;
    wire       rise_req1;
    wire       fall_req1;

    assign rise_req0 = rise_en_i[CH0];
    assign fall_req0 = fall_en_i[CH0];
    assign rise_req1 = rise_en_i[CH1];
    assign fall_req1 = fall_en_i[CH1];

    // Enables decoded from the registered modes
    wire       rise_cfg0;
    wire       fall_cfg0;
    wire       rise_cfg1;
    wire       fall_cfg1;

    // Pins and strobes per channel
    wire       pin0;
    wire       pin1;
    wire       strobe0;
    wire       strobe1;

    assign pin0 = latch_pin_i[CH0];                                 // [RULE5] [RULE9]
    assign pin1 = latch_pin_i[CH1];                                 // [RULE5] [RULE9]

    // Channel 0 mode follows its own enables only
    always @* begin
        if (chan_built(CH0)) begin
            next_mode0 = mode_of(rise_req0, fall_req0);             // [RULE4] [RULE11]
        end else begin
            next_mode0 = MODE_NONE;
        end
    end

    // Channel 1 stays idle when it is not built
    always @* begin
        if (chan_built(CH1)) begin
            next_mode1 = mode_of(rise_req1, fall_req1);             // [RULE4] [RULE11]
        end else begin
            next_mode1 = MODE_NONE;                                 // [RULE8]
        end
    end

    // Both senses off after reset
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode0 <= MODE_NONE;                                     // [RULE3]
        end else begin
            mode0 <= next_mode0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode1 <= MODE_NONE;                                     // [RULE3]
        end else begin
            mode1 <= next_mode1;
        end
    end

    assign rise_cfg0 = mode_rise(mode0);                            // [RULE1]
    assign fall_cfg0 = mode_fall(mode0);                            // [RULE2]
    assign rise_cfg1 = mode_rise(mode1);                            // [RULE1]
    assign fall_cfg1 = mode_fall(mode1);                            // [RULE2]

    // Channel 0 is present in every build
    led_channel u_ch0 (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     (pin0),
        .rise_en_i (rise_cfg0),
        .fall_en_i (fall_cfg0),
        .strobe_o  (strobe0)
    );

    generate
        if (NCH > CH1) begin : ch1_on
            led_channel u_ch1 (
                .sys_clk_i (sys_clk_i),
                .rst_i     (rst_i),
                .pin_i     (pin1),
                .rise_en_i (rise_cfg1),
                .fall_en_i (fall_cfg1),
                .strobe_o  (strobe1)
            );
        end else begin : ch1_off
            // No second pin watch and no second strobe in 32-bit use
            assign strobe1 = `LED_BIT_OFF;                          // [RULE7] [RULE8]
        end
    endgenerate

    // Strobe n drives the latch of counter stage n, which captures on high
    assign stage_latch_o[CH0] = strobe0;                            // [RULE6] [RULE10]
    assign stage_latch_o[CH1] = strobe1 & chan_built(CH1);          // [RULE6] [RULE7]

endmodule
`default_nettype wire

// file: tb/led_stage.sv
// Counter stage model: copies its running count on a latch strobe.
// Fed by detector output 0 on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module led_stage (input wire logic sys_clk_i, latch_i, output logic [7:0] hold_o);
    logic [7:0] cnt = 8'h00;
    always @(posedge sys_clk_i) begin cnt <= cnt + 8'h01; if (latch_i) hold_o <= cnt; end
endmodule
`default_nettype wire

// file: tb/led_latch_detect_asserts.sv
// Port assertions for the latch edge detector.
// Bound into led_latch_detect; pins assumed low through reset.
`timescale 1ns/1ps
`default_nettype none
module led_chk #(parameter WIDE32 = 0) (input wire logic sys_clk_i, rst_i,
    input wire logic [1:0] latch_pin_i, rise_en_i, fall_en_i, stage_latch_o);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_rise_strobe: assert property ($rose(latch_pin_i[0]) ##1 rise_en_i[0]
        |-> ##2 stage_latch_o[0]) else $error("rise lost");
    chk_fall_strobe: assert property (($fell(latch_pin_i[1]) && WIDE32 == 0)
        ##1 fall_en_i[1] |-> ##2 stage_latch_o[1]) else $error("fall lost");
    chk_stray_ch0: assert property (stage_latch_o[0] |->
        $past(rise_en_i[0], 2) || $past(fall_en_i[0], 2)) else $error("ch0 stray");
    chk_stray_ch1: assert property (stage_latch_o[1] |->
        $past(rise_en_i[1], 2) || $past(fall_en_i[1], 2)) else $error("ch1 stray");
    chk_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !stage_latch_o)
        else $error("strobe in reset");
    chk_wide_mute: assert property (WIDE32 == 0 || !stage_latch_o[1]) else $error("ch1");
endmodule
bind led_latch_detect led_chk #(.WIDE32(WIDE32)) led_chk_i (.*);
`default_nettype wire

// file: tb/led_latch_detect_tb_top.sv
// Bench: every enable pairing on both channels, one-cycle pin pulses.
// Runs the 16-bit and 32-bit builds; strobes are counted per channel.
`timescale 1ns/1ps
`default_nettype none
module led_latch_detect_tb_top;
    logic c = 1'b0, rst_i = 1'b1;
    logic [1:0] p = 2'h0, r = 2'h0, f = 2'h0, s, w;
    logic [7:0] m0 = 8'h00, m1 = 8'h00, e2 = 8'h00, h;
    logic [7:0] n0 = 8'h00, n1 = 8'h00, e0 = 8'h00, e1 = 8'h00, t = 8'h00;
    integer mismatches = 0, comparisons = 0;
    always #10 c = ~c;
    led_latch_detect led_latch_detect_i (.sys_clk_i(c), .rst_i(rst_i), .latch_pin_i(p),
        .rise_en_i(r), .fall_en_i(f), .stage_latch_o(s));
    led_latch_detect #(.WIDE32(1)) led_latch_detect_w_i (.sys_clk_i(c), .rst_i(rst_i),
        .latch_pin_i(p), .rise_en_i(r), .fall_en_i(f), .stage_latch_o(w));
    led_stage led_stage_i (.sys_clk_i(c), .latch_i(s[0]), .hold_o(h));
    always @(posedge c) {n0, n1, t} <= {n0 + s[0], n1 + s[1], t + 8'h01};
    always @(posedge c) {m0, m1} <= {m0 + w[0], m1 + w[1]};
    // Stage count and t both start at zero and step every clock
    always @(posedge c) if (s[0]) e2 <= t;
    always @(posedge c) if (&t) begin mismatches++; test_done; end
    task check(input logic [7:0] a, b);
        comparisons++;
        if (a !== b) begin mismatches++; $display("CHECK FAILED %0t count", $time); end
    endtask
    task test_done;
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge c);
        rst_i <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            {r, f} <= {k[1:0], k[3:2]};
            @(posedge c) p <= 2'h3;
            // Pin high one cycle only: rise and fall strobes come back to back
            repeat (6) @(posedge c) p <= 2'h0;
            {e0, e1} = {e0 + k[0] + k[2], e1 + k[1] + k[3]};
            check(n0, e0);
            check(n1, e1);
            check(m0, e0);
            check(m1, 8'h00);
            if (k[0] | k[2]) check(h, e2);
        end
        test_done;
    end
endmodule
`default_nettype wire
